// file: logic/bbm_mode_control.sv
/*
 Mode control for a boost pre-regulator feeding a buck post-regulator:
 modulation choice, stepped soft start, boost hysteresis, status flags.
 Assumes a decoded system mode from the mode machine on the same clock
 and asynchronous comparator results that are synchronised here.
*/
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module bbm_mode_control (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  bbm_pkg::bbm_mode_type      mode_i,
	input  wire logic                  stop_cmd_i,
	input  wire logic                  wake_input_pin_i,
	input  wire logic                  step_down_vout_low_i,
	input  wire logic                  step_down_target_i,
	input  wire logic                  step_down_window_i,
	input  wire logic                  step_down_switch_pin_open_i,
	input  wire logic                  step_down_switch_pin_short_i,
	input  wire logic                  load_high_i,
	input  wire logic [1:0]            supply_sense_below_i,
	input  wire logic [1:0]            supply_sense_above_i,
	input  wire logic                  step_up_pin_open_i,
	input  wire logic                  step_up_pin_short_i,
	input  wire logic                  step_up_lost_gnd_i,
	input  wire logic                  shunt_oc_i,
	input  wire logic                  gate_short_i,
	output logic                       regulator_enable_o,
	output logic                       step_down_pwm_o,
	output logic      [7:0]            step_down_duty_o,
	output logic                       hs_gate_o,
	output logic                       hs_soft_o,
	output logic                       ls_gate_o,
	output logic                       ls_soft_o,
	output logic                       step_up_level_o,
	output logic                       step_up_gate_o,
	output logic                       mod_event_o
);
	import bbm_pkg::*;

	logic [IN_W-1:0]   async_in;
	logic [IN_W-1:0]   meta_reg;
	logic [IN_W-1:0]   sync_reg;
	logic              wake_s;
	logic              vlow_s;
	logic              tgt_s;
	logic              load_s;
	logic              oc_s;
	logic              gsh_s;
	logic              below_s;
	logic              above_s;
	bbm_mode_type      prev_mode_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [STAT_W-1:0] stat_reg;
	logic [STAT_W-1:0] stat_set;
	logic [STAT_W-1:0] stat_clr;
	logic              en_next;
	logic              stop_entry;
	logic              up_allow;
	logic              ss_pend_reg;
	bbm_ss_type        ss_state_reg;
	logic [3:0]        hold_reg;
	logic [7:0]        dn_duty_reg;
	logic [7:0]        up_duty_reg;
	logic              pwm_target;
	logic              auto_pwm_reg;
	logic              auto_set;
	logic [7:0]        pfm_cnt_reg;
	logic              dn_on;
	logic              dn_bound;
	logic              up_on;
	logic              up_bound;
	logic              hs_raw;
	logic              hs_req;
	logic              ls_req;
	logic              up_run_reg;
	logic              oc_seen_reg;
	logic              kill_reg;
	logic              wb_req;
	logic              wr_ctrl;
	logic              wr_stat;
	logic [31:0]       rd_data;

	assign async_in = {gate_short_i, shunt_oc_i, step_up_lost_gnd_i,
		step_up_pin_short_i, step_up_pin_open_i, supply_sense_above_i,
		supply_sense_below_i, load_high_i, step_down_switch_pin_short_i,
		step_down_switch_pin_open_i, step_down_window_i,
		step_down_target_i, step_down_vout_low_i, wake_input_pin_i};

	// Only sync_reg is read; meta_reg may be metastable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign wake_s  = sync_reg[IN_WAKE];
	assign vlow_s  = sync_reg[IN_VLOW];
	assign tgt_s   = sync_reg[IN_TGT];
	assign load_s  = sync_reg[IN_LOAD];
	assign oc_s    = sync_reg[IN_OC];
	assign gsh_s   = sync_reg[IN_GSH];
	assign below_s = ctrl_reg[CTRL_BST_V] ? sync_reg[IN_TH1]
		: sync_reg[IN_TH0];
	assign above_s = ctrl_reg[CTRL_BST_V] ? sync_reg[IN_HY1]
		: sync_reg[IN_HY0];
	assign step_up_level_o  = ctrl_reg[CTRL_BST_V];
	assign step_down_duty_o = dn_duty_reg;

	assign en_next = (mode_i == MODE_NORMAL) || (mode_i == MODE_STOP)
		|| (mode_i == MODE_RESTART);
	assign stop_entry = (mode_i == MODE_STOP) && (prev_mode_reg != MODE_STOP);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_mode_reg      <= MODE_RESTART;
			regulator_enable_o <= 1'b0;
		end else begin
			prev_mode_reg      <= mode_i;
			regulator_enable_o <= en_next;
		end
	end

	sleep_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i == MODE_SLEEP || mode_i == MODE_FAILSAFE)
		|=> !regulator_enable_o)
		else $error("regulators on in sleep or fail-safe");

	// Power-up request comes from reset itself
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ss_pend_reg <= 1'b1;
		else if (mode_i == MODE_RESTART && (prev_mode_reg == MODE_SLEEP
			|| prev_mode_reg == MODE_FAILSAFE))
			ss_pend_reg <= 1'b1;
		else if (ss_state_reg == SS_OFF && regulator_enable_o && dn_bound)
			ss_pend_reg <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ss_state_reg <= SS_OFF;
			hold_reg     <= 4'h0;
			dn_duty_reg  <= DUTY_MIN;
		end else if (!regulator_enable_o) begin
			ss_state_reg <= SS_OFF;
			hold_reg     <= 4'h0;
			dn_duty_reg  <= DUTY_MIN;
		end else if (dn_bound) begin
			unique case (ss_state_reg)
			SS_OFF: begin
				hold_reg     <= 4'h0;
				dn_duty_reg  <= DUTY_MIN;
				ss_state_reg <= ss_pend_reg ? SS_HOLD : SS_REG;
			end
			SS_HOLD: begin
				if (tgt_s)
					ss_state_reg <= SS_REG;
				else if (hold_reg == SS_HOLD_PER - 4'h1) begin
					hold_reg <= 4'h0;
					if (dn_duty_reg > DUTY_FULL - DUTY_STEP)
						dn_duty_reg <= DUTY_FULL;
					else
						dn_duty_reg <= dn_duty_reg + DUTY_STEP;
				end else
					hold_reg <= hold_reg + 4'h1;
			end
			SS_REG: begin
				// Crude bang-bang loop; the analog loop refines it
				if (step_down_pwm_o && vlow_s && dn_duty_reg != DUTY_FULL)
					dn_duty_reg <= dn_duty_reg + 8'h01;
				else if (step_down_pwm_o && !vlow_s
					&& dn_duty_reg != DUTY_MIN)
					dn_duty_reg <= dn_duty_reg - 8'h01;
			end
			endcase
		end
	end

	ss_begin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ss_state_reg == SS_OFF && ss_pend_reg && regulator_enable_o
		&& dn_bound) |=> (ss_state_reg == SS_HOLD && dn_duty_reg == DUTY_MIN))
		else $error("soft start did not begin at minimum duty");

	ss_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ss_state_reg == SS_HOLD && !tgt_s && regulator_enable_o && dn_bound
		&& hold_reg == SS_HOLD_PER - 4'h1
		&& dn_duty_reg <= DUTY_FULL - DUTY_STEP)
		|=> dn_duty_reg == $past(dn_duty_reg) + DUTY_STEP)
		else $error("soft start step wrong");

	ss_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ss_state_reg == SS_HOLD && tgt_s && regulator_enable_o && dn_bound)
		|=> ss_state_reg == SS_REG)
		else $error("soft start kept stepping at target");

	full_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ss_state_reg == SS_REG && step_down_pwm_o && vlow_s && dn_bound
		&& regulator_enable_o && dn_duty_reg == DUTY_FULL - 8'h01)
		|=> dn_duty_reg == DUTY_FULL)
		else $error("duty did not reach full on-time");

	assign auto_set = (mode_i == MODE_STOP) && !stop_entry && !stop_cmd_i
		&& ctrl_reg[CTRL_AUTO] && !ctrl_reg[CTRL_PINF] && load_s
		&& !auto_pwm_reg;

	// Only a new stop command returns the buck to PFM
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_pwm_reg <= 1'b0;
			mod_event_o  <= 1'b0;
		end else begin
			mod_event_o <= auto_set;
			if (mode_i != MODE_STOP || stop_entry || stop_cmd_i)
				auto_pwm_reg <= 1'b0;
			else if (auto_set)
				auto_pwm_reg <= 1'b1;
		end
	end

	// Wake pin is used raw apart from the synchroniser
	assign pwm_target = (mode_i != MODE_STOP) ? 1'b1
		: (ctrl_reg[CTRL_PINF] ? wake_s : auto_pwm_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			step_down_pwm_o <= 1'b1;
		else if (dn_bound)
			step_down_pwm_o <= pwm_target;
	end

	run_pwm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		((mode_i == MODE_NORMAL || mode_i == MODE_RESTART) && dn_bound)
		|=> step_down_pwm_o)
		else $error("buck not in PWM in normal or restart");

	stop_pfm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i == MODE_STOP && !ctrl_reg[CTRL_PINF] && !auto_pwm_reg
		&& dn_bound) |=> !step_down_pwm_o)
		else $error("buck not in PFM in stop");

	pin_mod_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_i == MODE_STOP && ctrl_reg[CTRL_PINF] && dn_bound)
		|=> step_down_pwm_o == $past(wake_s))
		else $error("pin-forced modulation ignored wake pin");

	mod_evt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		auto_set |=> (mod_event_o && stat_reg[ST_MOD_CHG]))
		else $error("modulation change not reported");

	// Fixed on-time bursts in PFM, no fixed frequency
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pfm_cnt_reg <= 8'h00;
		else if (pfm_cnt_reg != 8'h00)
			pfm_cnt_reg <= pfm_cnt_reg - 8'h01;
		else if (!step_down_pwm_o && regulator_enable_o && vlow_s)
			pfm_cnt_reg <= PFM_ON_CYC;
	end

	bbm_pwm_gen u_dn_pwm (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.run_i   (regulator_enable_o),
		.duty_i  (dn_duty_reg),
		.on_o    (dn_on),
		.bound_o (dn_bound)
	);

	// Break-before-make between the two switches
	assign hs_raw = regulator_enable_o
		&& (step_down_pwm_o ? dn_on : (pfm_cnt_reg != 8'h00));
	assign hs_req = hs_raw && !ls_gate_o && !ls_soft_o;
	assign ls_req = regulator_enable_o && step_down_pwm_o && !hs_raw
		&& !hs_gate_o && !hs_soft_o;

	bbm_edge_shape u_hs_shape (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.req_i  (hs_req),
		.gate_o (hs_gate_o),
		.soft_o (hs_soft_o)
	);

	bbm_edge_shape u_ls_shape (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.req_i  (ls_req),
		.gate_o (ls_gate_o),
		.soft_o (ls_soft_o)
	);

	// Restart keeps the setting made in Normal
	assign up_allow = ctrl_reg[CTRL_BST_EN] && en_next;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			up_run_reg <= 1'b0;
		else if (!up_allow)
			up_run_reg <= 1'b0;
		else if (below_s)
			up_run_reg <= 1'b1;
		else if (above_s)
			up_run_reg <= 1'b0;
	end

	up_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!up_allow |=> !up_run_reg)
		else $error("boost ran while not allowed");

	up_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(up_allow && below_s) |=> up_run_reg)
		else $error("boost did not start below threshold");

	bbm_pwm_gen u_up_pwm (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.run_i   (up_run_reg),
		.duty_i  (up_duty_reg),
		.on_o    (up_on),
		.bound_o (up_bound)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			oc_seen_reg <= 1'b0;
		else if (up_bound)
			oc_seen_reg <= oc_s;
		else if (oc_s)
			oc_seen_reg <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			up_duty_reg <= DUTY_MIN;
		else if (!up_run_reg)
			up_duty_reg <= DUTY_MIN;
		else if (up_bound) begin
			if (oc_seen_reg)
				up_duty_reg <= (up_duty_reg < DUTY_MIN + OC_STEP) ? DUTY_MIN
					: up_duty_reg - OC_STEP;
			else if (!above_s && up_duty_reg < BST_DUTY_MAX)
				up_duty_reg <= up_duty_reg + 8'h01;
			else if (above_s && up_duty_reg > DUTY_MIN)
				up_duty_reg <= up_duty_reg - 8'h01;
		end
	end

	oc_cut_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(oc_seen_reg && up_bound && up_run_reg
		&& up_duty_reg >= DUTY_MIN + OC_STEP)
		|=> up_duty_reg == $past(up_duty_reg) - OC_STEP)
		else $error("overcurrent did not cut boost duty");

	// A short seen on the boundary still kills the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			kill_reg <= 1'b0;
		else if (gsh_s)
			kill_reg <= 1'b1;
		else if (up_bound)
			kill_reg <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			step_up_gate_o <= 1'b0;
		else
			step_up_gate_o <= up_on && !kill_reg && !gsh_s;
	end

	gate_kill_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gsh_s |=> (!step_up_gate_o && stat_reg[ST_GATE_SH]))
		else $error("gate short did not stop the gate");

	// Status is report-only and feeds no control path
	always_comb begin
		stat_set               = '0;
		stat_set[ST_DN_OPEN]   = sync_reg[IN_SWO];
		stat_set[ST_DN_SHORT]  = sync_reg[IN_SWS];
		stat_set[ST_DN_WIN]    = sync_reg[IN_WIN];
		stat_set[ST_UP_OPEN]   = sync_reg[IN_UPO];
		stat_set[ST_UP_SHORT]  = sync_reg[IN_UPS];
		stat_set[ST_UP_GND]    = sync_reg[IN_GND];
		stat_set[ST_GATE_SH]   = gsh_s;
		stat_set[ST_UP_ACTIVE] = up_allow && below_s && !up_run_reg;
		stat_set[ST_MOD_CHG]   = auto_set;
	end

	always_comb begin
		stat_clr = '0;
		if (wr_stat && wb_sel_i[0])
			stat_clr[7:0] = wb_dat_i[7:0];
		if (wr_stat && wb_sel_i[1])
			stat_clr[8] = wb_dat_i[8];
		if (below_s)
			stat_clr[ST_UP_ACTIVE] = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			stat_reg <= STAT_RST;
		else
			stat_reg <= (stat_reg & ~stat_clr) | stat_set;
	end

	act_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(stat_reg[ST_UP_ACTIVE] && below_s) |=> stat_reg[ST_UP_ACTIVE])
		else $error("active flag cleared below threshold");

	assign wb_req  = wb_cyc_i && wb_stb_i;
	assign wr_ctrl = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0]
		&& (wb_adr_i == ADDR_CTRL);
	assign wr_stat = wb_req && wb_we_i && wb_ack_o && (wb_adr_i == ADDR_STAT);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_reg <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_reg <= wb_dat_i[CTRL_W-1:0];
	end

	always_comb begin
		rd_data = '0;
		case (wb_adr_i)
		ADDR_CTRL: rd_data[CTRL_W-1:0] = ctrl_reg;
		ADDR_STAT: rd_data[STAT_W-1:0] = stat_reg;
		ADDR_LIVE: begin
			rd_data[LV_EN]          = regulator_enable_o;
			rd_data[LV_PWM]         = step_down_pwm_o;
			rd_data[LV_UP_RUN]      = up_run_reg;
			rd_data[LV_SS]          = (ss_state_reg != SS_REG);
			rd_data[LV_DN_DUTY +: 8] = dn_duty_reg;
			rd_data[LV_UP_DUTY +: 8] = up_duty_reg;
		end
		default: rd_data = '0;
		endcase
	end

	// One wait state; writes land on the acknowledged edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			if (wb_req && !wb_ack_o)
				wb_dat_o <= rd_data;
		end
	end
endmodule // bbm_mode_control

// file: logic/bbm_pkg.sv
/*
 Shared constants and types for the buck/boost mode control block.
 Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
*/
package bbm_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_STOP,
		MODE_RESTART,
		MODE_SLEEP,
		MODE_FAILSAFE
	} bbm_mode_type;

	typedef enum logic [1:0] {SS_OFF, SS_HOLD, SS_REG} bbm_ss_type;

	localparam int         CLK_KHZ      = 25000;
	localparam int         SW_KHZ       = 100;
	localparam logic [7:0] PERIOD_CYC   = 8'(CLK_KHZ / SW_KHZ);
	localparam logic [7:0] DUTY_FULL    = PERIOD_CYC;
	localparam logic [7:0] DUTY_MIN     = 8'h0a;
	localparam logic [7:0] DUTY_STEP    = 8'h0a;
	localparam logic [7:0] BST_DUTY_MAX = 8'hc8;
	localparam logic [7:0] OC_STEP      = 8'h10;
	localparam logic [3:0] SS_HOLD_PER  = 4'h8;
	localparam int         PFM_ON_NS    = 1000;
	localparam logic [7:0] PFM_ON_CYC   =
		8'((PFM_ON_NS * CLK_KHZ + 999999) / 1000000);
	localparam int         EDGE_NS      = 80;
	localparam logic [2:0] EDGE_CYC     =
		3'((EDGE_NS * CLK_KHZ + 999999) / 1000000);

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_LIVE = 8'h08;

	localparam int         CTRL_BST_EN = 0;
	localparam int         CTRL_BST_V  = 1;
	localparam int         CTRL_AUTO   = 2;
	localparam int         CTRL_PINF   = 3;
	localparam int         CTRL_W      = 4;
	localparam logic [3:0] CTRL_RST    = 4'h6;

	localparam int         ST_DN_OPEN   = 0;
	localparam int         ST_DN_SHORT  = 1;
	localparam int         ST_DN_WIN    = 2;
	localparam int         ST_UP_OPEN   = 3;
	localparam int         ST_UP_SHORT  = 4;
	localparam int         ST_UP_GND    = 5;
	localparam int         ST_GATE_SH   = 6;
	localparam int         ST_UP_ACTIVE = 7;
	localparam int         ST_MOD_CHG   = 8;
	localparam int         STAT_W       = 9;
	localparam logic [8:0] STAT_RST     = 9'h000;

	localparam int LV_EN      = 0;
	localparam int LV_PWM     = 1;
	localparam int LV_UP_RUN  = 2;
	localparam int LV_SS      = 3;
	localparam int LV_DN_DUTY = 8;
	localparam int LV_UP_DUTY = 16;

	localparam int IN_WAKE  = 0;
	localparam int IN_VLOW  = 1;
	localparam int IN_TGT   = 2;
	localparam int IN_WIN   = 3;
	localparam int IN_SWO   = 4;
	localparam int IN_SWS   = 5;
	localparam int IN_LOAD  = 6;
	localparam int IN_TH0   = 7;
	localparam int IN_TH1   = 8;
	localparam int IN_HY0   = 9;
	localparam int IN_HY1   = 10;
	localparam int IN_UPO   = 11;
	localparam int IN_UPS   = 12;
	localparam int IN_GND   = 13;
	localparam int IN_OC    = 14;
	localparam int IN_GSH   = 15;
	localparam int IN_W     = 16;
endpackage

// file: logic/bbm_pwm_gen.sv
/*
 Fixed-frequency period counter with duty compare.
 Assumes duty is changed by the caller only at the period boundary.
*/
`timescale 1ns/100ps
module bbm_pwm_gen (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       run_i,
	input  wire logic [7:0] duty_i,
	output logic            on_o,
	output logic            bound_o
);
	import bbm_pkg::*;

	logic [7:0] cnt_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cnt_reg <= 8'h00;
		else if (cnt_reg == PERIOD_CYC - 8'h01)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end

	// Duty equal to the period gives full on-time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_o    <= 1'b0;
			bound_o <= 1'b0;
		end else begin
			on_o    <= run_i && (cnt_reg < duty_i);
			bound_o <= (cnt_reg == PERIOD_CYC - 8'h01);
		end
	end
endmodule // bbm_pwm_gen

// file: logic/bbm_edge_shape.sv
/*
 Switch edge shaper: a controlled-current phase before each gate change.
 Assumes the request is a synchronous level from the same clock.
*/
`timescale 1ns/100ps
module bbm_edge_shape (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic req_i,
	output logic      gate_o,
	output logic      soft_o
);
	import bbm_pkg::*;

	logic [2:0] cnt_reg;
	logic       tgt_reg;

	// Soft phase lasts EDGE_CYC cycles, then the gate takes the target
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_o  <= 1'b0;
			soft_o  <= 1'b0;
			tgt_reg <= 1'b0;
			cnt_reg <= 3'h0;
		end else if (soft_o) begin
			if (cnt_reg == 3'h0) begin
				soft_o <= 1'b0;
				gate_o <= tgt_reg;
			end else
				cnt_reg <= cnt_reg - 3'h1;
		end else if (req_i != gate_o) begin
			soft_o  <= 1'b1;
			tgt_reg <= req_i;
			cnt_reg <= EDGE_CYC - 3'h1;
		end
	end
endmodule // bbm_edge_shape

// file: verification/bbm_far_side.sv
/*
 Far-side model: decoded mode machine and comparator levels.
 Assumes the bench commands changes through the tasks below; t_status clears cmp_o directly.
*/
`timescale 1ns/100ps
module bbm_far_side (
	input  wire logic            clk_i,
	output bbm_pkg::bbm_mode_type mode_o,
	output logic      [15:0]     cmp_o,
	output logic                 stop_o
);
	import bbm_pkg::*;
	initial begin
		mode_o = MODE_NORMAL;
		cmp_o = 16'h0000;
		stop_o = 1'b0;
	end
	// Mode is a decoded level, moved only on a clock edge
	task set_mode(input bbm_mode_type m);
		@(posedge clk_i);
		mode_o <= m;
	endtask
	task set_cmp(input int i, input logic v);
		@(posedge clk_i);
		cmp_o[i] <= v;
	endtask
	task stop_pulse;
		@(posedge clk_i);
		stop_o <= 1'b1;
		@(posedge clk_i);
		stop_o <= 1'b0;
	endtask
endmodule // bbm_far_side

// file: verification/tb_bbm_mode_control.sv
/*
 Self-checking bench for the mode control block.
 Assumes one 25 MHz clock and the far-side model for mode and comparators.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_bbm_mode_control;
	import bbm_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rd, dat_o;
	logic ack, en, pwm, lvl, ev, stp, upg, hsg, hss, lsg, lss;
	logic [7:0] dn;
	logic [15:0] cmp;
	bbm_mode_type mode;
	int errors = 0, checks = 0, cycles = 0;
	int n_up, n_sh, n_ov;
	always #20 clk_i = ~clk_i;
	bbm_far_side far (.clk_i(clk_i), .mode_o(mode), .cmp_o(cmp), .stop_o(stp));
	bbm_mode_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .mode_i(mode),
		.stop_cmd_i(stp), .wake_input_pin_i(cmp[IN_WAKE]),
		.step_down_vout_low_i(cmp[IN_VLOW]), .step_down_target_i(cmp[IN_TGT]),
		.step_down_window_i(cmp[IN_WIN]),
		.step_down_switch_pin_open_i(cmp[IN_SWO]),
		.step_down_switch_pin_short_i(cmp[IN_SWS]), .load_high_i(cmp[IN_LOAD]),
		.supply_sense_below_i({cmp[IN_TH1], cmp[IN_TH0]}),
		.supply_sense_above_i({cmp[IN_HY1], cmp[IN_HY0]}),
		.step_up_pin_open_i(cmp[IN_UPO]), .step_up_pin_short_i(cmp[IN_UPS]),
		.step_up_lost_gnd_i(cmp[IN_GND]), .shunt_oc_i(cmp[IN_OC]),
		.gate_short_i(cmp[IN_GSH]), .regulator_enable_o(en),
		.step_down_pwm_o(pwm), .step_down_duty_o(dn), .hs_gate_o(hsg),
		.hs_soft_o(hss), .ls_gate_o(lsg), .ls_soft_o(lss),
		.step_up_level_o(lvl), .step_up_gate_o(upg), .mod_event_o(ev));
	// Requests held until ack is sampled high at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task wait_pwm(input logic v);
		int n;
		for (n = 0; n < 600 && pwm !== v; n++) @(posedge clk_i);
	endtask
	// One whole switching period; unknown levels count as high
	task watch;
		n_up = 0;
		n_sh = 0;
		n_ov = 0;
		repeat (PERIOD_CYC) begin
			@(posedge clk_i);
			if (upg !== 1'b0) n_up++;
			if (hss !== 1'b0) n_sh++;
			if (((hsg | hss) & (lsg | lss)) !== 1'b0) n_ov++;
		end
	endtask
	task t_reset_map;
		bus(0, ADDR_CTRL, 0); `CHK("ctrl", 32'h6, rd)
		bus(0, ADDR_STAT, 0); `CHK("stat", 32'h0, rd)
		bus(0, 8'h20, 0); `CHK("unmapped", 32'h0, rd)
	endtask
	task t_modes;
		bbm_mode_type m;
		m = m.first();
		repeat (5) begin
			far.set_mode(m);
			repeat (3) @(posedge clk_i);
			`CHK("enable", m inside {MODE_NORMAL, MODE_STOP, MODE_RESTART}, en)
			m = m.next();
		end
		far.set_mode(MODE_NORMAL);
	endtask
	task t_boost;
		bus(1, ADDR_CTRL, 32'h7);
		far.set_cmp(IN_TH0, 1); repeat (8) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0); `CHK("wrong level", 1'b0, rd[LV_UP_RUN])
		`CHK("level out", 1'b1, lvl)
		far.set_cmp(IN_TH1, 1); repeat (8) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0); `CHK("boost run", 1'b1, rd[LV_UP_RUN])
		bus(1, ADDR_STAT, 32'h80); bus(0, ADDR_STAT, 0);
		`CHK("active kept", 1'b1, rd[ST_UP_ACTIVE])
		far.set_cmp(IN_TH1, 0); far.set_cmp(IN_TH0, 0); far.set_cmp(IN_HY1, 1);
		repeat (8) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0); `CHK("boost stop", 1'b0, rd[LV_UP_RUN])
		bus(1, ADDR_STAT, 32'h80); bus(0, ADDR_STAT, 0);
		`CHK("active clr", 1'b0, rd[ST_UP_ACTIVE])
		far.set_cmp(IN_HY1, 0);
	endtask
	task t_status;
		foreach (cmp[i]) if (i inside {IN_WIN, IN_SWO, IN_SWS, IN_UPO,
			IN_UPS, IN_GND}) far.set_cmp(i, 1);
		repeat (6) @(posedge clk_i);
		bus(0, ADDR_STAT, 0); `CHK("flags", 32'h3f, rd)
		`CHK("no mode chg", 1'b1, en)
		bus(0, ADDR_CTRL, 0); `CHK("no cfg chg", 32'h7, rd)
		far.cmp_o <= 16'h0000; repeat (6) @(posedge clk_i);
		bus(1, ADDR_STAT, 32'h3f); bus(0, ADDR_STAT, 0);
		`CHK("cleared", 32'h0, rd)
	endtask
	task t_stop;
		int n;
		bus(1, ADDR_CTRL, 32'h4); far.set_mode(MODE_STOP);
		wait_pwm(0); `CHK("stop pfm", 1'b0, pwm)
		far.set_cmp(IN_LOAD, 1);
		for (n = 0; n < 10 && ev !== 1'b1; n++) @(posedge clk_i);
		`CHK("event", 1'b1, ev)
		wait_pwm(1); `CHK("auto pwm", 1'b1, pwm)
		bus(0, ADDR_STAT, 0); `CHK("mod flag", 1'b1, rd[ST_MOD_CHG])
		bus(1, ADDR_CTRL, 32'h0); far.stop_pulse();
		repeat (600) @(posedge clk_i); `CHK("auto off", 1'b0, pwm)
		far.set_cmp(IN_LOAD, 0); bus(1, ADDR_CTRL, 32'h8);
		far.set_cmp(IN_WAKE, 1); wait_pwm(1); `CHK("pin hi", 1'b1, pwm)
		far.set_cmp(IN_WAKE, 0); wait_pwm(0); `CHK("pin lo", 1'b0, pwm)
		far.set_mode(MODE_NORMAL); wait_pwm(1);
		`CHK("normal pwm", 1'b1, pwm)
	endtask
	// Ramp long enough that one overcurrent cut is a full step
	task t_up;
		bus(1, ADDR_CTRL, 32'h1);
		far.set_cmp(IN_TH0, 1);
		repeat (4500) @(posedge clk_i);
		watch();
		`CHK("up gate", 1'b1, n_up > 0)
		`CHK("buck edges", 1'b1, n_sh > 0)
		`CHK("overlap", 0, n_ov)
		far.set_cmp(IN_OC, 1);
		repeat (600) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0);
		`CHK("oc cut", DUTY_MIN, rd[LV_UP_DUTY +: 8])
		far.set_cmp(IN_OC, 0);
		far.set_cmp(IN_GSH, 1);
		repeat (4) @(posedge clk_i);
		watch();
		`CHK("gate killed", 0, n_up)
		bus(0, ADDR_STAT, 0);
		`CHK("gate flag", 1'b1, rd[ST_GATE_SH])
		far.set_cmp(IN_GSH, 0);
		far.set_cmp(IN_TH0, 0);
	endtask
	// First read falls before the first duty step, second between first and second
	task t_soft;
		far.set_mode(MODE_SLEEP);
		repeat (4) @(posedge clk_i);
		far.set_mode(MODE_RESTART);
		repeat (260) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0);
		`CHK("ss restart", 1'b1, rd[LV_SS])
		`CHK("ss min", DUTY_MIN, rd[LV_DN_DUTY +: 8])
		`CHK("duty out", DUTY_MIN, dn)
		repeat (2000) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0);
		`CHK("ss step", DUTY_MIN + DUTY_STEP, rd[LV_DN_DUTY +: 8])
		far.set_cmp(IN_TGT, 1);
		repeat (260) @(posedge clk_i);
		bus(0, ADDR_LIVE, 0);
		`CHK("ss done", 1'b0, rd[LV_SS])
		far.set_cmp(IN_TGT, 0);
		far.set_mode(MODE_NORMAL);
	endtask
	task final_report;
		if (errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Ceiling about twice the cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_map(); t_modes(); t_boost(); t_status(); t_stop();
		t_up(); t_soft();
		final_report();
	end
endmodule // tb_bbm_mode_control
